// [rtl/pedups_pkg.sv]
package pedups_pkg;

   // register index on the plain software port
   localparam int         ADDR_W     = 2;
   localparam logic [1:0] ADDR_DIR   = 2'h0;
   localparam logic [1:0] ADDR_UPPER = 2'h1;
   localparam logic [1:0] ADDR_LOWER = 2'h2;

   // reset values, taken on power-on reset; RDATA_RESET is also the read data of every cycle without a read
   localparam logic [15:0] DIR_RESET   = 16'h0000;
   localparam logic [15:0] UPPER_RESET = 16'h0000;
   localparam logic [15:0] LOWER_RESET = 16'h0000;
   localparam logic [15:0] RDATA_RESET = 16'h0000;

   // writable bits; the rest are reserved and read as zero
   localparam logic [15:0] UPPER_MASK = 16'hfd55;
   localparam logic [15:0] LOWER_MASK = 16'h55ff;

   // role field positions in the upper role register (pins 15..8)
   localparam int P15_LSB = 14;
   localparam int P14_LSB = 12;
   localparam int P13_LSB = 10;
   localparam int P12_BIT = 8;
   localparam int P11_BIT = 6;
   localparam int P10_BIT = 4;
   localparam int P9_BIT  = 2;
   localparam int P8_BIT  = 0;

   // role field positions in the lower role register (pins 7..0)
   localparam int P7_BIT = 14;
   localparam int P6_BIT = 12;
   localparam int P5_BIT = 10;
   localparam int P4_BIT = 8;
   localparam int P3_LSB = 6;
   localparam int P2_LSB = 4;
   localparam int P1_LSB = 2;
   localparam int P0_LSB = 0;

   // role codes of a two-bit field
   localparam logic [1:0] CODE_GPIO  = 2'h0;
   localparam logic [1:0] CODE_TIMER = 2'h1;
   localparam logic [1:0] CODE_ALT1  = 2'h2;
   localparam logic [1:0] CODE_ALT2  = 2'h3;

   // decoded role of one pin
   typedef enum logic [3:0] {
      PR_GPIO,
      PR_TIMER,
      PR_DMA_ACKNOWLEDGE_1,
      PR_DMA_ACKNOWLEDGE_0,
      PR_IRQ,
      PR_AHOLD,
      PR_MANUAL_RESET_IN,
      PR_DMA_REQUEST_ACK_1,
      PR_DMA_REQUEST_ACK_0,
      PR_DREQ1,
      PR_DREQ0
   } pedups_role_t;

   typedef pedups_role_t [15:0] pedups_roles_t;

   // peripheral levels that may be routed out to a pin
   typedef struct packed {
      logic dma_acknowledge_1;
      logic dma_acknowledge_0;
      logic dma_request_ack_1;
      logic dma_request_ack_0;
      logic irq_n;
      logic ahold_n;
   } pedups_periph_t;

   // peripheral inputs taken from a pin
   typedef struct packed {
      logic manual_reset_in_req;
      logic dreq1;
      logic dreq0;
   } pedups_pin_req_t;

   // whole state of the top module
   typedef struct packed {
      logic [15:0]     dir;
      logic [15:0]     upper;
      logic [15:0]     lower;
      logic [15:0]     rdata;
      logic [15:0]     pin_sync1;
      logic [15:0]     pin_sync2;
      logic            mode_sync1;
      logic            mode_sync2;
      logic [15:0]     pin_out;
      logic [15:0]     pin_oe;
      pedups_pin_req_t req;
   } pedups_state_t;

   localparam pedups_state_t STATE_RESET = '{
      dir:        DIR_RESET,
      upper:      UPPER_RESET,
      lower:      LOWER_RESET,
      rdata:      RDATA_RESET,
      pin_sync1:  16'h0000,
      pin_sync2:  16'h0000,
      mode_sync1: 1'b0,
      mode_sync2: 1'b0,
      pin_out:    16'h0000,
      pin_oe:     16'h0000,
      req:        '{manual_reset_in_req: 1'b0, dreq1: 1'b1, dreq0: 1'b1}
   };

endpackage

// [rtl/pedups_role_dec.sv]
`timescale 1ns/1ps
module pedups_role_dec
   import pedups_pkg::*;
(
   input  wire logic [15:0]   upper,        // upper role register
   input  wire logic [15:0]   lower,        // lower role register
   input  wire logic          single_chip,  // synchronised single-chip mode
   output pedups_roles_t      roles         // decoded role per pin
);

   // one-bit field: general I/O or timer pin
   function automatic pedups_role_t dec_bit(input logic code);
      dec_bit = code ? PR_TIMER : PR_GPIO;
   endfunction

   // two-bit field; reserved or mode-killed codes fall back to general I/O
   function automatic pedups_role_t dec_pair(input logic [1:0] code,
                                             input pedups_role_t alt1,
                                             input pedups_role_t alt2);
      case (code)
         CODE_TIMER: dec_pair = PR_TIMER;
         CODE_ALT1:  dec_pair = alt1;
         CODE_ALT2:  dec_pair = alt2;
         default:    dec_pair = PR_GPIO;
      endcase
   endfunction

   // upper pins follow the upper register, lower pins the lower one
   always_comb begin
      roles[15] = dec_pair(upper[P15_LSB +: 2],
                           single_chip ? PR_GPIO : PR_DMA_ACKNOWLEDGE_1,
                           single_chip ? PR_GPIO : PR_IRQ);
      roles[14] = dec_pair(upper[P14_LSB +: 2],
                           single_chip ? PR_GPIO : PR_DMA_ACKNOWLEDGE_0,
                           single_chip ? PR_GPIO : PR_AHOLD);
      roles[13] = dec_pair(upper[P13_LSB +: 2], PR_MANUAL_RESET_IN, PR_GPIO);
      roles[12] = dec_bit(upper[P12_BIT]);
      roles[11] = dec_bit(upper[P11_BIT]);
      roles[10] = dec_bit(upper[P10_BIT]);
      roles[9]  = dec_bit(upper[P9_BIT]);
      roles[8]  = dec_bit(upper[P8_BIT]);
      roles[7]  = dec_bit(lower[P7_BIT]);
      roles[6]  = dec_bit(lower[P6_BIT]);
      roles[5]  = dec_bit(lower[P5_BIT]);
      roles[4]  = dec_bit(lower[P4_BIT]);
      roles[3]  = dec_pair(lower[P3_LSB +: 2], single_chip ? PR_GPIO : PR_DMA_REQUEST_ACK_1, PR_GPIO);
      roles[2]  = dec_pair(lower[P2_LSB +: 2], single_chip ? PR_GPIO : PR_DREQ1, PR_GPIO);
      roles[1]  = dec_pair(lower[P1_LSB +: 2], single_chip ? PR_GPIO : PR_DMA_REQUEST_ACK_0, PR_GPIO);
      roles[0]  = dec_pair(lower[P0_LSB +: 2], single_chip ? PR_GPIO : PR_DREQ0, PR_GPIO);
   end

endmodule

// [rtl/pedups_top.sv]
`timescale 1ns/1ps
// How it works
// - a pin in general I/O or timer role is driven when its direction bit is 1, input when 0.
// - for any other role the direction bit has no effect on the pin.
// - the direction register is 16 read/write bits, bit n for pin n.
// - the direction register clears only on power-on reset and otherwise holds.
// - both role registers clear only on power-on reset and otherwise hold.
// - the upper role register serves pins 15 to 8, the lower one pins 7 to 0.
// - pin 15 field: general I/O, timer, DMA ack 1, interrupt out; single-chip remaps.
// - pin 14 field: general I/O, timer, DMA ack 0, address hold; single-chip gives I/O.
// - pin 13 field: general I/O, timer, manual reset input, reserved.
// - one-bit fields for pins 12 to 8 pick general I/O at 0 and timer at 1.
// - odd upper bits below 10 are reserved, read 0, and software writes 0.
// - in single-chip mode the DMA and address hold choices give general I/O.
module pedups_top
   import pedups_pkg::*;
(
   input  wire logic              CLK,          // 200 MHz system clock
   input  wire logic              SYS_RST,      // power-on reset, synchronous
   input  wire logic [ADDR_W-1:0] ADDR,         // register index
   input  wire logic [15:0]       WDATA,        // write data
   input  wire logic              WR_EN,        // write strobe
   input  wire logic              RD_EN,        // read strobe
   output logic      [15:0]       RDATA,        // read data, cycle after strobe
   input  wire logic              SINGLE_CHIP,  // mode pin level, asynchronous
   input  wire logic [15:0]       GPIO_OUT,     // port data to drive
   input  wire logic [15:0]       TMR_OUT,      // timer compare levels
   input  pedups_periph_t         PERIPH,       // dma, irq and hold levels
   input  wire logic [15:0]       PIN_IN,       // pad input levels
   output logic      [15:0]       PIN_OUT,      // pad output levels
   output logic      [15:0]       PIN_OE,       // pad output enables
   output logic      [15:0]       PIN_LEVEL,    // synchronised pad levels
   output pedups_pin_req_t        PIN_REQ       // manual reset and dma requests
);

   pedups_state_t st_reg;
   pedups_state_t st_next;
   pedups_roles_t roles;

   // roles come from the stored registers, so pin changes lag a write by one cycle
   pedups_role_dec pedups_role_dec_inst (
      .upper       (st_reg.upper),
      .lower       (st_reg.lower),
      .single_chip (st_reg.mode_sync2),
      .roles       (roles)
   );

   // next state: synchronisers, register file, read port and pin drive
   always_comb begin
      st_next = st_reg;

      // pads and mode pin come from outside, two flops before use
      st_next.pin_sync1  = PIN_IN;
      st_next.pin_sync2  = st_reg.pin_sync1;
      st_next.mode_sync1 = SINGLE_CHIP;
      st_next.mode_sync2 = st_reg.mode_sync1;

      // software writes; reserved bits are forced to zero at store time
      if (WR_EN) begin
         case (ADDR)
            ADDR_DIR:   st_next.dir   = WDATA;
            ADDR_UPPER: st_next.upper = WDATA & UPPER_MASK;
            ADDR_LOWER: st_next.lower = WDATA & LOWER_MASK;
            default:    st_next.dir   = st_reg.dir;
         endcase
      end

      // read data stand for exactly one cycle, zero otherwise
      st_next.rdata = RDATA_RESET;
      if (RD_EN) begin
         case (ADDR)
            ADDR_DIR:   st_next.rdata = st_reg.dir;
            ADDR_UPPER: st_next.rdata = st_reg.upper & UPPER_MASK;
            ADDR_LOWER: st_next.rdata = st_reg.lower & LOWER_MASK;
            default:    st_next.rdata = RDATA_RESET;
         endcase
      end

      // per-pin drive; only I/O and timer roles look at the direction bit
      for (int i = 0; i < 16; i++) begin
         case (roles[i])
            PR_GPIO: begin
               st_next.pin_oe[i]  = st_reg.dir[i];
               st_next.pin_out[i] = GPIO_OUT[i];
            end
            PR_TIMER: begin
               st_next.pin_oe[i]  = st_reg.dir[i];
               st_next.pin_out[i] = TMR_OUT[i];
            end
            PR_DMA_ACKNOWLEDGE_1: begin
               st_next.pin_oe[i]  = 1'b1;
               st_next.pin_out[i] = PERIPH.dma_acknowledge_1;
            end
            PR_DMA_ACKNOWLEDGE_0: begin
               st_next.pin_oe[i]  = 1'b1;
               st_next.pin_out[i] = PERIPH.dma_acknowledge_0;
            end
            PR_DMA_REQUEST_ACK_1: begin
               st_next.pin_oe[i]  = 1'b1;
               st_next.pin_out[i] = PERIPH.dma_request_ack_1;
            end
            PR_DMA_REQUEST_ACK_0: begin
               st_next.pin_oe[i]  = 1'b1;
               st_next.pin_out[i] = PERIPH.dma_request_ack_0;
            end
            PR_IRQ: begin
               st_next.pin_oe[i]  = 1'b1;
               st_next.pin_out[i] = PERIPH.irq_n;
            end
            PR_AHOLD: begin
               st_next.pin_oe[i]  = 1'b1;
               st_next.pin_out[i] = PERIPH.ahold_n;
            end
            PR_MANUAL_RESET_IN, PR_DREQ1, PR_DREQ0: begin
               st_next.pin_oe[i]  = 1'b0;
               st_next.pin_out[i] = 1'b0;
            end
            default: begin
               st_next.pin_oe[i]  = st_reg.dir[i];
               st_next.pin_out[i] = GPIO_OUT[i];
            end
         endcase
      end

      // input roles: dma requests idle high and the manual reset request idles low unless the pin carries them
      st_next.req.manual_reset_in_req = (roles[13] == PR_MANUAL_RESET_IN) && !st_reg.pin_sync2[13];
      st_next.req.dreq1    = (roles[2] == PR_DREQ1) ? st_reg.pin_sync2[2] : 1'b1;
      st_next.req.dreq0    = (roles[0] == PR_DREQ0) ? st_reg.pin_sync2[0] : 1'b1;
   end

   // SYS_RST stands for power-on reset only; nothing else clears the registers
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st_reg <= STATE_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // every output straight from the state flops
   assign RDATA     = st_reg.rdata;
   assign PIN_OUT   = st_reg.pin_out;
   assign PIN_OE    = st_reg.pin_oe;
   assign PIN_LEVEL = st_reg.pin_sync2;
   assign PIN_REQ   = st_reg.req;

   // helper: pins whose role honours the direction bit
   logic [15:0] dir_pins;
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         dir_pins[i] = (roles[i] == PR_GPIO) || (roles[i] == PR_TIMER);
      end
   end

   // direction bit reaches the enable of an I/O or timer pin one cycle later
   chk_dir_to_oe: assert property (@(posedge CLK) disable iff (SYS_RST)
      1'b1 |=> ((PIN_OE & $past(dir_pins)) == ($past(st_reg.dir) & $past(dir_pins))))
      else $error("direction bit not reflected on pin enable");

   // a dma acknowledge pin drives whatever the direction bit says
   chk_dack_ignores_dir: assert property (@(posedge CLK) disable iff (SYS_RST)
      (roles[15] == PR_DMA_ACKNOWLEDGE_1) && !st_reg.dir[15] |=> PIN_OE[15] && (PIN_OUT[15] == $past(PERIPH.dma_acknowledge_1)))
      else $error("dma acknowledge pin not driven");

   // a direction write is stored whole and reads back
   chk_dir_write_read: assert property (@(posedge CLK) disable iff (SYS_RST)
      WR_EN && (ADDR == ADDR_DIR) ##1 RD_EN && (ADDR == ADDR_DIR) |=> RDATA == $past(WDATA, 2))
      else $error("direction register readback mismatch");

   // reset leaves all three registers clear
   chk_reset_clear: assert property (@(posedge CLK)
      $past(SYS_RST) |-> (st_reg.dir == DIR_RESET) && (st_reg.upper == UPPER_RESET)
                         && (st_reg.lower == LOWER_RESET))
      else $error("registers not cleared by reset");

   // lower register alone steers pin 7
   chk_lower_pin7: assert property (@(posedge CLK) disable iff (SYS_RST)
      st_reg.lower[P7_BIT] |-> roles[7] == PR_TIMER)
      else $error("pin 7 role not taken from lower register");

   // pin 15 code 11 outside single-chip mode is the interrupt output
   chk_pin15_irq: assert property (@(posedge CLK) disable iff (SYS_RST)
      !st_reg.mode_sync2 && (st_reg.upper[P15_LSB +: 2] == CODE_ALT2) |=>
      PIN_OE[15] && (PIN_OUT[15] == $past(PERIPH.irq_n)))
      else $error("pin 15 interrupt output not routed");

   // pin 14 code 11 outside single-chip mode is address hold
   chk_pin14_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
      !st_reg.mode_sync2 && (st_reg.upper[P14_LSB +: 2] == CODE_ALT2) |-> roles[14] == PR_AHOLD)
      else $error("pin 14 address hold not decoded");

   // manual reset role turns a low pad into a request within three cycles
   chk_manual_reset_in_path: assert property (@(posedge CLK) disable iff (SYS_RST)
      (roles[13] == PR_MANUAL_RESET_IN) && !PIN_IN[13] ##1 (roles[13] == PR_MANUAL_RESET_IN) [*2] |=>
      PIN_REQ.manual_reset_in_req && !PIN_OE[13])
      else $error("manual reset request not raised");

   // pin 12 one-bit field picks the timer role
   chk_pin12_timer: assert property (@(posedge CLK) disable iff (SYS_RST)
      st_reg.upper[P12_BIT] |-> roles[12] == PR_TIMER)
      else $error("pin 12 timer role not decoded");

   // reserved bits of the upper register always read as zero
   chk_upper_rsv: assert property (@(posedge CLK) disable iff (SYS_RST)
      RD_EN && (ADDR == ADDR_UPPER) |=> (RDATA & ~UPPER_MASK) == 16'h0000)
      else $error("reserved role bits read nonzero");

   // single-chip mode turns the dma acknowledge choice into plain I/O
   chk_sc_override: assert property (@(posedge CLK) disable iff (SYS_RST)
      st_reg.mode_sync2 && (st_reg.upper[P14_LSB +: 2] == CODE_ALT1) |-> roles[14] == PR_GPIO)
      else $error("single-chip override ignored");

   // a reserved code on pin 13 behaves as I/O under the direction bit
   chk_rsv_code_gpio: assert property (@(posedge CLK) disable iff (SYS_RST)
      (st_reg.upper[P13_LSB +: 2] == CODE_ALT2) |=> PIN_OE[13] == $past(st_reg.dir[13]))
      else $error("reserved code did not fall back to general I/O");

endmodule

// [verif/tb_pedups_top.sv]
`timescale 1ns/1ps
module tb_pedups_top;
   import pedups_pkg::*;

   // one comparison, counted; four-state inequality so an unknown never matches
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("unexpected at %0t: %s", $time, msg); end end

   logic              CLK = 1'b0;
   logic              SYS_RST = 1'b1;
   logic [ADDR_W-1:0] ADDR = '0;
   logic [15:0]       WDATA = 16'h0000;
   logic              WR_EN = 1'b0;
   logic              RD_EN = 1'b0;
   logic [15:0]       RDATA;
   logic              SINGLE_CHIP = 1'b0;
   logic [15:0]       GPIO_OUT = 16'h0000;
   logic [15:0]       TMR_OUT = 16'h0000;
   pedups_periph_t    PERIPH = '0;
   logic [15:0]       PIN_IN = 16'h0000;
   logic [15:0]       PIN_OUT;
   logic [15:0]       PIN_OE;
   logic [15:0]       PIN_LEVEL;
   pedups_pin_req_t   PIN_REQ;
   int                fail_count = 0;
   int                n_checks = 0;
   int                cyc = 0;
   logic [31:0]       seed = 32'h7ee0f50b;
   logic [15:0]       sh_dir, sh_up, sh_lo, rv;

   pedups_top pedups_top_inst (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
      .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA), .SINGLE_CHIP(SINGLE_CHIP),
      .GPIO_OUT(GPIO_OUT), .TMR_OUT(TMR_OUT), .PERIPH(PERIPH), .PIN_IN(PIN_IN),
      .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_LEVEL(PIN_LEVEL), .PIN_REQ(PIN_REQ));

   // 200 MHz clock
   always #2.5 CLK = ~CLK;

   // xorshift source, fixed seed keeps every run the same
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // expected {enables, levels} of all sixteen pads from registers and inputs
   function automatic logic [31:0] exp_pins(logic [15:0] d, u, l, logic sc);
      logic [15:0] oe;
      logic [15:0] o;
      logic [1:0]  c;
      oe = d;
      o  = GPIO_OUT;
      for (int k = 0; k < 5; k++) if (u[2*k]) o[8+k] = TMR_OUT[8+k];
      for (int k = 0; k < 4; k++) if (l[8+2*k]) o[4+k] = TMR_OUT[4+k];
      for (int k = 0; k < 4; k++) begin
         c = l[2*k +: 2];
         if (c == CODE_TIMER) o[k] = TMR_OUT[k];
         else if (c == CODE_ALT1 && !sc) begin
            oe[k] = k[0];
            o[k]  = (k == 3) ? PERIPH.dma_request_ack_1 : (k == 1) ? PERIPH.dma_request_ack_0 : 1'b0;
         end
      end
      c = u[15:14];
      if (c == CODE_TIMER) o[15] = TMR_OUT[15];
      else if (c != CODE_GPIO && !sc) begin
         oe[15] = 1'b1;
         o[15]  = (c == CODE_ALT1) ? PERIPH.dma_acknowledge_1 : PERIPH.irq_n;
      end
      c = u[13:12];
      if (c == CODE_TIMER) o[14] = TMR_OUT[14];
      else if (c != CODE_GPIO && !sc) begin
         oe[14] = 1'b1;
         o[14]  = (c == CODE_ALT1) ? PERIPH.dma_acknowledge_0 : PERIPH.ahold_n;
      end
      c = u[11:10];
      if (c == CODE_TIMER) o[13] = TMR_OUT[13];
      else if (c == CODE_ALT1) begin
         oe[13] = 1'b0;
         o[13]  = 1'b0;
      end
      return {oe, o};
   endfunction

   // one write cycle on the plain port
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge CLK);
      ADDR  <= a;
      WDATA <= d;
      WR_EN <= 1'b1;
      @(posedge CLK);
      WR_EN <= 1'b0;
   endtask

   // one read cycle; data stand only in the following cycle
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge CLK);
      ADDR  <= a;
      RD_EN <= 1'b1;
      @(posedge CLK);
      RD_EN <= 1'b0;
      #1 d = RDATA;
      @(posedge CLK);
      #1 `CHK(RDATA, 16'h0000, "read data did not return to zero")
   endtask

   // read back all three registers against the shadow copies
   task automatic chk_regs();
      rd(ADDR_DIR, rv);
      `CHK(rv, sh_dir, "direction readback")
      rd(ADDR_UPPER, rv);
      `CHK(rv, sh_up & UPPER_MASK, "upper role readback")
      rd(ADDR_LOWER, rv);
      `CHK(rv, sh_lo & LOWER_MASK, "lower role readback")
   endtask

   // let synchronisers and output flops settle, then compare every pad
   task automatic chk_pins();
      logic [31:0]     e;
      pedups_pin_req_t q;
      repeat (4) @(posedge CLK);
      #1 e = exp_pins(sh_dir, sh_up & UPPER_MASK, sh_lo & LOWER_MASK, SINGLE_CHIP);
      q.manual_reset_in_req = (sh_up[11:10] == CODE_ALT1) && !PIN_IN[13];
      q.dreq1 = (sh_lo[5:4] == CODE_ALT1 && !SINGLE_CHIP) ? PIN_IN[2] : 1'b1;
      q.dreq0 = (sh_lo[1:0] == CODE_ALT1 && !SINGLE_CHIP) ? PIN_IN[0] : 1'b1;
      `CHK(PIN_OE, e[31:16], "pad enables")
      `CHK(PIN_OUT & e[31:16], e[15:0] & e[31:16], "pad levels")
      `CHK(PIN_LEVEL, PIN_IN, "synchronised pad levels")
      `CHK(PIN_REQ, q, "pin requests")
   endtask

   // closing report, reached from the main sequence or the watchdog
   task automatic conclude();
      if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // watchdog over the whole run
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         $display("unexpected at %0t: run did not finish", $time);
         conclude();
      end
   end

   initial begin
      sh_dir = 16'h0000;
      sh_up  = 16'h0000;
      sh_lo  = 16'h0000;
      repeat (6) @(posedge CLK);
      #1 `CHK(PIN_OE, 16'h0000, "enables in reset")
      `CHK(PIN_REQ, STATE_RESET.req, "requests in reset")
      SYS_RST <= 1'b0;
      chk_regs();
      // write to pad takes exactly two edges
      wr(ADDR_DIR, 16'hffff);
      #1 `CHK(PIN_OE, 16'h0000, "enable moved too early")
      @(posedge CLK);
      #1 `CHK(PIN_OE, 16'hffff, "enable two edges after write")
      sh_dir = 16'hffff;
      // write then read of the same index back to back sees the new value
      @(posedge CLK);
      ADDR  <= ADDR_DIR;
      WDATA <= 16'ha5c3;
      WR_EN <= 1'b1;
      @(posedge CLK);
      WR_EN <= 1'b0;
      RD_EN <= 1'b1;
      @(posedge CLK);
      RD_EN <= 1'b0;
      #1 `CHK(RDATA, 16'ha5c3, "read right after write")
      sh_dir = 16'ha5c3;
      // software keeps reserved bits at zero; unmapped index ignored
      wr(ADDR_UPPER, UPPER_MASK);
      sh_up = UPPER_MASK;
      wr(2'h3, 16'h5a5a);
      rd(2'h3, rv);
      `CHK(rv, 16'h0000, "unmapped read")
      chk_regs();
      chk_pins();
      // every role code of every field, in both modes, among random traffic
      for (int i = 0; i < 80; i++) begin
         sh_dir = 16'(rnd());
         sh_up  = (i < 8) ? {8{i[1:0]}} & UPPER_MASK : 16'(rnd()) & UPPER_MASK;
         sh_lo  = (i < 8) ? {8{i[1:0]}} & LOWER_MASK : 16'(rnd()) & LOWER_MASK;
         wr(ADDR_DIR, sh_dir);
         wr(ADDR_UPPER, sh_up);
         wr(ADDR_LOWER, sh_lo);
         SINGLE_CHIP <= (i < 8) ? i[2] : 1'(rnd());
         GPIO_OUT    <= 16'(rnd());
         TMR_OUT     <= 16'(rnd());
         PERIPH      <= pedups_periph_t'(6'(rnd()));
         PIN_IN      <= 16'(rnd());
         chk_pins();
         if (i % 10 == 0) chk_regs();
      end
      // second power-on reset in mid-run clears all registers
      SYS_RST <= 1'b1;
      repeat (2) @(posedge CLK);
      SYS_RST <= 1'b0;
      sh_dir = 16'h0000;
      sh_up  = 16'h0000;
      sh_lo  = 16'h0000;
      chk_regs();
      chk_pins();
      conclude();
   end
endmodule
